// ### asr_pkg.sv
// Behaviour
// - Timing mode picked at each chip-select fall; host keeps clock low for external mode.
// - Before readout data out shows pending flag: 1 converting, 0 asleep with result.
// - A finished conversion drops into sleep on its own once a result is buffered, chip select regardless.
// - Sleep holds result static until chip select is low and, in external mode, a clock rise has arrived.
// - Data in sampled on every clock rise, data out changed on every fall.
// - The 32nd falling edge starts a conversion and drives data out high.
// - Chip select rising mid-frame abandons readout and starts a conversion at once.
// - Chip select rising before the last config bit keeps the old configuration.
// - Three-wire external mode: serial clock alone starts conversion and runs readout.
// - Internal single-cycle mode: device makes the clock, chip-select fall controls it.
// - Internal three-wire mode: continuous conversion, readout on the device's own clock.
// - Conversion clock from internal oscillator unless the pin carries an external one.
package asr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int CNT_W = 8;
  localparam int FRAME_BITS = 32;
  localparam int RES_W = 31;
  localparam int CFG_W = 4;
  localparam int TOGGLES = 2 * FRAME_BITS;
  localparam logic [CFG_W-1:0] CFG_RST = 4'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int T_CONV_INT_US = 133000;
  localparam int CONV_INT_CYC = T_CONV_INT_US * CLK_MHZ;
  localparam int CONV_EXT_TICKS = 41036;
  localparam int T_EOC_TEST_US = 12;
  localparam int EOC_TEST_CYC = T_EOC_TEST_US * CLK_MHZ;
  localparam int T_SCK_HALF_NS = 250;
  localparam int SCK_HALF_CYC = (T_SCK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int T_OSC_LOST_NS = 2000;
  localparam int OSC_LOST_CYC = T_OSC_LOST_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    ST_CONVERT = 2'b00,
    ST_SLEEP = 2'b01,
    ST_READOUT = 2'b10
  } asr_state_e;

  function automatic logic [CNT_W-1:0] asr_bin2gray(input logic [CNT_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CNT_W-1:0] asr_gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = g;
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ### asr_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module asr_buf2 #(
  parameter int W = 31
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  if (W < 1) begin : g_chk
    $error("asr_buf2: width must be positive");
  end

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wr;
    logic rd;
    logic [1:0] cnt;
  } asr_buf_s;

  asr_buf_s r;
  asr_buf_s n;
  logic push;
  logic pop;

  assign inReady = (r.cnt != 2'h2);
  assign outValid = (r.cnt != 2'h0);
  assign outData = r.mem[r.rd];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wr] = inData;
      n.wr = ~r.wr;
    end
    if (pop) begin
      n.rd = ~r.rd;
    end
    n.cnt = 2'(r.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule
`default_nettype wire

// ### asr_readout.sv
`timescale 1ns/1ps
`default_nettype none
module asr_readout #(
  parameter int P_CONV_INT_CYC = asr_pkg::CONV_INT_CYC,
  parameter int P_CONV_EXT_TICKS = asr_pkg::CONV_EXT_TICKS
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  input wire logic serialClk,
  input wire logic csN,
  input wire logic sdi,
  output logic sdoOut,
  output logic sdoOe,
  output logic sckOut,
  output logic sckOe,
  // Conversion clock pin
  input wire logic convClkPin,
  // Results from the modulator
  input wire logic resultValid,
  output logic resultReady,
  input wire logic [asr_pkg::RES_W-1:0] resultData,
  // Status and configuration
  output logic eocN,
  output logic intMode,
  output logic [asr_pkg::CFG_W-1:0] cfgWord
);
  import asr_pkg::*;

  if (P_CONV_INT_CYC < 1 || P_CONV_EXT_TICKS < 1) begin : g_chk
    $error("asr_readout: conversion lengths must be positive");
  end

  // ****************************************
  // State types
  // ****************************************
  typedef struct packed {
    asr_state_e st;
    logic csS1, csS2, csPrev;
    logic sckS1, sckS2;
    logic oscS1, oscS2, oscPrev;
    logic [CNT_W-1:0] rg1, rg2, fg1, fg2;
    logic [CNT_W-1:0] baseR, baseF;
    logic intMode, eocN, sdoOe, sckOut, sckOe, cfgTaken;
    logic [CFG_W-1:0] cfg;
    logic [RES_W-1:0] result;
    logic [31:0] convCnt;
    logic [15:0] oscIdle, sckCnt;
    logic [6:0] toggles;
  } asr_core_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gray;
    logic [CFG_W-1:0] shift;
    logic [CFG_W-1:0] cap;
  } asr_rise_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gray;
    logic [CNT_W-1:0] seenBase;
    logic active;
    logic bit_;
  } asr_fall_s;

  asr_core_s r, c;
  asr_rise_s lr, lrn;
  asr_fall_s lf, lfn;

  logic bufValid;
  logic bufPop;
  logic [RES_W-1:0] bufData;
  logic [CNT_W-1:0] riseBin, fallBin, nRise, nFall;
  logic csFall, csRise, csLow, oscEdge, extOsc, tick, convDone;
  logic [31:0] convLen;

  // ****************************************
  // Result buffer
  // ****************************************
  asr_buf2 #(.W(RES_W)) u_buf (
    .clk(clk),
    .nrst(nrst),
    .inValid(resultValid),
    .inReady(resultReady),
    .inData(resultData),
    .outValid(bufValid),
    .outReady(bufPop),
    .outData(bufData)
  );

  // ****************************************
  // Link side, rising edges
  // ****************************************
  always_comb begin
    logic [CNT_W-1:0] n;
    n = '0;
    lrn = lr;
    n = CNT_W'(lr.cnt + 8'h01 - r.baseR);
    lrn.cnt = CNT_W'(lr.cnt + 8'h01);
    lrn.gray = asr_bin2gray(lrn.cnt);
    lrn.shift = {lr.shift[CFG_W-2:0], sdi};
    if (n == CNT_W'(CFG_W)) begin
      lrn.cap = lrn.shift;
    end
  end

  // Link clock stops between frames, so reset cannot wait for its edges
  always_ff @(posedge serialClk or negedge nrst) begin
    if (!nrst) begin
      lr <= '0;
    end else begin
      lr <= lrn;
    end
  end

  // ****************************************
  // Link side, falling edges
  // ****************************************
  always_comb begin
    logic [CNT_W-1:0] n;
    logic [FRAME_BITS-1:0] frame;
    n = '0;
    frame = '0;
    lfn = lf;
    n = CNT_W'(lf.cnt + 8'h01 - r.baseF);
    frame = {1'b0, r.result};
    lfn.cnt = CNT_W'(lf.cnt + 8'h01);
    lfn.gray = asr_bin2gray(lfn.cnt);
    lfn.seenBase = r.baseF;
    lfn.active = (n != '0);
    if (n < CNT_W'(FRAME_BITS)) begin
      lfn.bit_ = frame[5'(CNT_W'(FRAME_BITS - 1) - n)];
    end else begin
      lfn.bit_ = 1'b1;
    end
  end

  always_ff @(negedge serialClk or negedge nrst) begin
    if (!nrst) begin
      lf <= '0;
    end else begin
      lf <= lfn;
    end
  end

  // ****************************************
  // Core decode
  // ****************************************
  assign riseBin = asr_gray2bin(r.rg2);
  assign fallBin = asr_gray2bin(r.fg2);
  assign nRise = CNT_W'(riseBin - r.baseR);
  assign nFall = CNT_W'(fallBin - r.baseF);
  assign csFall = r.csPrev & ~r.csS2;
  assign csRise = ~r.csPrev & r.csS2;
  assign csLow = ~r.csS2;
  assign oscEdge = r.oscS2 & ~r.oscPrev;
  assign extOsc = (r.oscIdle < 16'(OSC_LOST_CYC));
  assign tick = extOsc ? oscEdge : 1'b1;
  assign convLen = extOsc ? 32'(P_CONV_EXT_TICKS) : 32'(P_CONV_INT_CYC);
  assign convDone = (r.convCnt >= convLen);
  assign bufPop = (r.st == ST_CONVERT) & convDone;

  // ****************************************
  // Core next state
  // ****************************************
  always_comb begin
    c = r;
    c.csS1 = csN;
    c.csS2 = r.csS1;
    c.csPrev = r.csS2;
    c.sckS1 = serialClk;
    c.sckS2 = r.sckS1;
    c.oscS1 = convClkPin;
    c.oscS2 = r.oscS1;
    c.oscPrev = r.oscS2;
    c.rg1 = lr.gray;
    c.rg2 = r.rg1;
    c.fg1 = lf.gray;
    c.fg2 = r.fg1;
    if (oscEdge) begin
      c.oscIdle = 16'h0000;
    end else if (r.oscIdle != 16'hFFFF) begin
      c.oscIdle = 16'(r.oscIdle + 16'h0001);
    end
    c.sdoOe = csLow;
    if (csFall) begin
      c.baseR = riseBin;
      // Own clock drops at select, skip that fall
      c.baseF = CNT_W'(fallBin + CNT_W'(r.sckS2));
      c.cfgTaken = 1'b0;
      c.intMode = r.sckS2;
    end
    case (r.st)
      ST_CONVERT: begin
        c.sckOut = 1'b0;
        if (tick && !convDone) begin
          c.convCnt = 32'(r.convCnt + 32'h0000_0001);
        end
        if (convDone && bufValid) begin
          c.result = bufData;
          c.st = ST_SLEEP;
          c.eocN = 1'b0;
          c.convCnt = 32'h0000_0000;
        end
      end
      ST_SLEEP: begin
        if (csLow && !csFall) begin
          if (r.intMode) begin
            c.st = ST_READOUT;
            c.sckCnt = 16'h0000;
            c.toggles = 7'h00;
          end else if (nRise != '0) begin
            c.st = ST_READOUT;
          end
        end
      end
      ST_READOUT: begin
        if (!r.cfgTaken && nRise >= CNT_W'(CFG_W)) begin
          c.cfg = lr.cap;
          c.cfgTaken = 1'b1;
        end
        if (csRise) begin
          c.st = ST_CONVERT;
          c.eocN = 1'b1;
          c.sckOut = 1'b0;
        end else if (nFall >= CNT_W'(FRAME_BITS)) begin
          c.st = ST_CONVERT;
          c.eocN = 1'b1;
          c.baseR = CNT_W'(r.baseR + CNT_W'(FRAME_BITS));
          c.baseF = CNT_W'(r.baseF + CNT_W'(FRAME_BITS));
          c.cfgTaken = 1'b0;
        end else if (r.intMode && csLow) begin
          c.sckCnt = 16'(r.sckCnt + 16'h0001);
          if ((r.toggles == 7'h00 && r.sckCnt >= 16'(EOC_TEST_CYC - 1)) ||
              (r.toggles != 7'h00 && r.sckCnt >= 16'(SCK_HALF_CYC - 1))) begin
            c.sckCnt = 16'h0000;
            if (r.toggles < 7'(TOGGLES)) begin
              c.sckOut = ~r.sckOut;
              c.toggles = 7'(r.toggles + 7'h01);
            end
          end
        end
      end
      default: begin
        c.st = ST_CONVERT;
      end
    endcase
    c.sckOe = c.intMode & csLow;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
      r.st <= ST_CONVERT;
      r.csS1 <= 1'b1;
      r.csS2 <= 1'b1;
      r.csPrev <= 1'b1;
      r.eocN <= 1'b1;
      r.cfg <= CFG_RST;
      r.oscIdle <= 16'hFFFF;
    end else begin
      r <= c;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Flag until readout bits
  assign sdoOut = (lf.active && lf.seenBase == r.baseF) ? lf.bit_ : r.eocN;
  assign sdoOe = r.sdoOe;
  assign sckOut = r.sckOut;
  assign sckOe = r.sckOe;
  assign eocN = r.eocN;
  assign intMode = r.intMode;
  assign cfgWord = r.cfg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_float;
    csLow ##1 !csLow |=> !sdoOe;
  endproperty
  a_float: assert property (p_float) else $error("data out driven while deselected");

  property p_flag;
    $fell(eocN) |-> $past(r.st) == ST_CONVERT && r.st == ST_SLEEP;
  endproperty
  a_flag: assert property (p_flag) else $error("flag fell outside conversion end");

  property p_sleep;
    r.st == ST_CONVERT && convDone && bufValid |=> r.st == ST_SLEEP && !eocN;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep after conversion");

  property p_hold;
    r.st == ST_SLEEP && !r.intMode && nRise == '0 |=> r.st == ST_SLEEP && $stable(r.result);
  endproperty
  a_hold: assert property (p_hold) else $error("sleep left without clock");

  property p_end;
    r.st == ST_READOUT && !csRise && nFall >= CNT_W'(FRAME_BITS) |=> r.st == ST_CONVERT && eocN;
  endproperty
  a_end: assert property (p_end) else $error("frame end missed");

  property p_abort;
    r.st == ST_READOUT && csRise |=> r.st == ST_CONVERT ##1 r.convCnt <= 32'h0000_0001;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not reconvert");

  property p_keep;
    r.st != ST_READOUT || r.cfgTaken || nRise < CNT_W'(CFG_W) |=> $stable(cfgWord);
  endproperty
  a_keep: assert property (p_keep) else $error("config changed without full word");

  property p_base;
    csFall |=> r.baseR == $past(riseBin) && r.intMode == $past(r.sckS2);
  endproperty
  a_base: assert property (p_base) else $error("frame count or mode not latched");

  c_frame: cover property (r.st == ST_READOUT ##[1:1000] r.st == ST_CONVERT && !csLow);
  c_abort: cover property (r.st == ST_READOUT && csRise);
  c_int: cover property (r.intMode && r.st == ST_READOUT && sckOut);

endmodule
`default_nettype wire

// ### asr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_host_model (
  // Serial pins driven by the host
  output var logic sck,
  output var logic csN,
  output var logic sdi,
  output var logic sckDrv,
  // Serial data back from the device
  input wire logic sdo
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
    sckDrv = 1'b1;
  end

  task automatic sel(input logic drv);
    sckDrv = drv;
    sck = 1'b0;
    csN = 1'b0;
    #200;
  endtask

  task automatic desel();
    csN = 1'b1;
    sckDrv = 1'b1;
    #100;
  endtask

  // flag first, last bit on rise 32
  task automatic frame(input int n, input logic [3:0] cfg, output logic [31:0] rx);
    rx = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      sdi = (i < 4) ? cfg[3-i] : 1'b0;
      #62.5 sck = 1'b1;
      rx = {rx[30:0], sdo};
      #62.5 sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### asr_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asr_readout_tb;
  import asr_pkg::*;
  logic clk, nrst, sdoOut, sdoOe, sckOut, sckOe, convClkPin, resultValid, resultReady;
  logic eocN, intMode, feedOn, extOsc;
  logic [RES_W-1:0] resultData;
  logic [CFG_W-1:0] cfgWord, cfgNow;
  logic [2:0] oscDiv;
  logic [31:0] rx;
  logic [RES_W-1:0] expQ[$];
  wire logic hostSck, csN, sdi, sckDrv;
  wire logic serialClk, sdoPin;
  int errors, nTests, nStall;
  int seed = 51;
  localparam int SIM_CONV_INT = 50;
  localparam int SIM_CONV_EXT = 20;

  // Pull-up on the clock pin when nobody drives it
  assign serialClk = sckOe ? sckOut : (sckDrv ? hostSck : 1'b1);
  assign sdoPin = sdoOe ? sdoOut : 1'bz;

  asr_readout #(
    .P_CONV_INT_CYC(SIM_CONV_INT),
    .P_CONV_EXT_TICKS(SIM_CONV_EXT)
  ) i_dut (
    .clk(clk),
    .nrst(nrst),
    .serialClk(serialClk),
    .csN(csN),
    .sdi(sdi),
    .sdoOut(sdoOut),
    .sdoOe(sdoOe),
    .sckOut(sckOut),
    .sckOe(sckOe),
    .convClkPin(convClkPin),
    .resultValid(resultValid),
    .resultReady(resultReady),
    .resultData(resultData),
    .eocN(eocN),
    .intMode(intMode),
    .cfgWord(cfgWord)
  );
  asr_host_model i_host (
    .sck(hostSck),
    .csN(csN),
    .sdi(sdi),
    .sckDrv(sckDrv),
    .sdo(sdoPin)
  );

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // ****************************************
  // Result feeder and reference queue
  // ****************************************
  always @(posedge clk) begin
    if (!nrst) begin
      nStall <= 0;
      oscDiv <= 3'h0;
      convClkPin <= 1'b0;
      resultData <= RES_W'($random(seed));
    end else begin
      if (resultValid && !resultReady) nStall <= nStall + 1;
      if (resultValid && resultReady) begin
        expQ.push_back(resultData);
        resultData <= RES_W'($random(seed));
      end
      oscDiv <= oscDiv + 3'h1;
      if (extOsc) convClkPin <= oscDiv[2];
    end
    resultValid <= nrst && (feedOn || (resultValid && !resultReady));
  end

  // ****************************************
  // Checks and helpers
  // ****************************************
  task automatic chk_bit(input string nm, input logic e, input logic g);
    nTests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_eoc();
    int k;
    k = 0;
    while (eocN !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk_bit("eocN", 1'b0, eocN);
  endtask

  task automatic rd_frame(input logic [3:0] cfg);
    logic [31:0] e;
    e = {1'b0, expQ.pop_front()};
    i_host.frame(32, cfg, rx);
    chk_word("frame", e, rx);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #1000000;
    errors++;
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    errors = 0;
    nTests = 0;
    nrst = 1'b0;
    feedOn = 1'b0;
    extOsc = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    feedOn <= 1'b1;
    for (int t = 0; t < 3; t++) begin
      cfgNow = 4'(t * 5 + 3);
      wait_eoc();
      repeat (100) @(posedge clk);
      i_host.sel(1'b1);
      repeat (4) @(posedge clk);
      chk_bit("sdoOe", 1'b1, sdoOe);
      chk_bit("flag", 1'b0, sdoOut);
      chk_bit("intMode", 1'b0, intMode);
      rd_frame(cfgNow);
      #5;
      chk_bit("sdoEnd", 1'b1, sdoOut);
      repeat (6) @(posedge clk);
      chk_bit("eocBusy", 1'b1, eocN);
      chk_word("cfg", 32'(cfgNow), 32'(cfgWord));
      wait_eoc();
      chk_bit("flagLow", 1'b0, sdoOut);
      cfgNow = ~cfgNow;
      rd_frame(cfgNow);
      i_host.desel();
      repeat (4) @(posedge clk);
      chk_bit("sdoOeOff", 1'b0, sdoOe);
      chk_word("cfg3w", 32'(cfgNow), 32'(cfgWord));
      $display("test frame %0d done", t);
    end
    wait_eoc();
    i_host.sel(1'b1);
    i_host.frame(2, ~cfgNow, rx);
    i_host.desel();
    chk_word("abortBits", 32'({1'b0, expQ[0][RES_W-1]}), rx);
    void'(expQ.pop_front());
    repeat (5) @(posedge clk);
    chk_bit("eocAbort", 1'b1, eocN);
    chk_word("cfgKept", 32'(cfgNow), 32'(cfgWord));
    $display("test abort done");
    i_host.sel(1'b0);
    repeat (4) @(posedge clk);
    chk_bit("intMode", 1'b1, intMode);
    chk_bit("sckLow", 1'b0, serialClk);
    chk_bit("sckOe", 1'b1, sckOe);
    wait_eoc();
    rx = 32'h0000_0000;
    for (int i = 0; i < FRAME_BITS; i++) begin
      @(posedge serialClk);
      rx = {rx[30:0], sdoPin};
    end
    chk_word("intFrame", {1'b0, expQ.pop_front()}, rx);
    i_host.desel();
    $display("test internal clock done");
    extOsc <= 1'b1;
    wait_eoc();
    i_host.sel(1'b1);
    rd_frame(cfgNow);
    i_host.desel();
    repeat (100) @(posedge clk);
    chk_bit("eocExt", 1'b1, eocN);
    wait_eoc();
    extOsc <= 1'b0;
    $display("test oscillator done");
    feedOn <= 1'b0;
    while (expQ.size() > 0) begin
      wait_eoc();
      i_host.sel(1'b1);
      rd_frame(cfgNow);
      i_host.desel();
    end
    repeat (300) @(posedge clk);
    chk_bit("eocStarved", 1'b1, eocN);
    chk_bit("stalled", 1'b1, nStall > 0);
    feedOn <= 1'b1;
    wait_eoc();
    i_host.sel(1'b1);
    rd_frame(cfgNow);
    i_host.desel();
    $display("test buffer done");
    end_of_test();
  end
endmodule
`default_nettype wire
